/* logic/codeword_trigger_front_end.sv */
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
// Behaviour
// - main trigger flag set on detection
// - trigger fires on chosen edge or level
// - separate auxiliary trigger flag
// - selector picks sequencer trigger source
// - status while port or link triggers
// - data from port or link, never both
// - qualifier bit index 16 to 31
// - qualifier polarity none, low, high, any
// - input word right shifted 0 to 31
// - shifted word ANDed with 10-bit mask
// - status word of lines seen high
// - status word of lines seen low
// - flag data change with strobe change
// - start waits for all synced channels
module codeword_trigger_front_end
    import cw_trig_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    input  wire logic [31:0] portData,
    input  wire logic        portStrobe,
    input  wire logic [31:0] linkData,
    input  wire logic        linkStrobe,
    input  wire logic        trigIn,
    input  wire logic        auxTrigIn,
    input  wire logic [3:0]  digTrig,
    input  wire logic        syncAllReady,
    output logic             syncReady,
    output logic             progStart,
    output logic             seqTrig,
    output logic [9:0]       codeword,
    output logic             codewordValid,
    output logic             irq
);
    // ****************************************
    // declarations
    // ****************************************
    logic [31:0] ctrlReg;                   // control word
    logic [31:0] cfgReg;                    // shift and mask
    logic [ST_WIDTH-1:0] statusReg;         // sticky events
    logic [ST_WIDTH-1:0] maskReg;           // interrupt enables
    logic [31:0] highReg;                   // lines seen high
    logic [31:0] lowReg;                    // lines seen low
    logic [31:0] portS1Reg;                 // first sync stage, port data
    logic [31:0] portS2Reg;                 // second sync stage, port data
    logic [31:0] portPrevReg;               // previous synced port data
    logic [5:0]  ctlS1Reg;                  // first sync stage, single pins
    logic [5:0]  ctlS2Reg;                  // second sync stage, single pins
    logic [3:0]  digS1Reg;                  // first sync stage, extra triggers
    logic [3:0]  digS2Reg;                  // second sync stage, extra triggers
    logic        strobePrevReg;             // previous strobe level
    logic        startedReg;                // program running
    logic [9:0]  codewordReg;               // captured codeword
    logic        cwValidReg;                // one-cycle capture pulse
    logic        seqTrigReg;                // registered sequencer trigger
    logic [31:0] regRdataReg;               // read data
    logic        trigFire;                  // main trigger event
    logic        auxFire;                   // auxiliary trigger event
    logic        strobeEdge;                // strobe rose
    logic        dataEdge;                  // data and strobe changed together
    logic        qualOk;                    // qualifier satisfies polarity
    logic        capture;                   // take codeword now
    logic [31:0] srcWord;                   // selected input word
    logic        srcStrobe;                 // selected strobe level
    logic        digSel;                    // selected digital trigger
    logic        qualBit;                   // selected qualifier bit
    logic [ST_WIDTH-1:0] events;            // this cycle's events
    logic [ST_WIDTH-1:0] w1c;               // write-one-to-clear bits

    // codeword extraction, used by the capture path
    function automatic logic [9:0] extract(input logic [31:0] w, input logic [4:0] sh,
                                           input logic [9:0] m);
        logic [31:0] t;
        t = w >> sh;
        return t[9:0] & m;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    // link inputs come from outside the clock domain too, so all pass two stages
    always_ff @(posedge mclk) begin
        if (srst) begin
            portS1Reg <= 32'h0;
            portS2Reg <= 32'h0;
            ctlS1Reg  <= 6'h0;
            ctlS2Reg  <= 6'h0;
            digS1Reg  <= 4'h0;
            digS2Reg  <= 4'h0;
        end else begin
            portS1Reg <= ctrlReg[CTRL_LINK_BIT] ? linkData : portData;
            portS2Reg <= portS1Reg;
            ctlS1Reg  <= {syncAllReady, auxTrigIn, trigIn,
                          ctrlReg[CTRL_LINK_BIT] ? linkStrobe : portStrobe, 2'b00};
            ctlS2Reg  <= ctlS1Reg;
            // extra triggers are pins too, never read before two stages
            digS1Reg  <= digTrig;
            digS2Reg  <= digS1Reg;
        end
    end

    assign srcWord   = portS2Reg;
    assign srcStrobe = ctlS2Reg[2];

    // ****************************************
    // trigger detection
    // ****************************************
    // edge or level trigger
    edge_sense mainSense (
        .mclk  (mclk),
        .srst  (srst),
        .level (ctlS2Reg[3]),
        .slope (ctrlReg[CTRL_SLOPE_LSB +: 2]),
        .fire  (trigFire)
    );

    edge_sense auxSense (
        .mclk  (mclk),
        .srst  (srst),
        .level (ctlS2Reg[4]),
        .slope (ctrlReg[CTRL_SLOPE_LSB +: 2]),
        .fire  (auxFire)
    );

    // ****************************************
    // qualifier and strobe timing
    // ****************************************
    // qualifier index
    assign qualBit = srcWord[{1'b1, ctrlReg[CTRL_VIDX_LSB +: 4]}];

    always_comb begin
        case (vpol_e'(ctrlReg[CTRL_VPOL_LSB +: 2]))
            POL_NONE: qualOk = 1'b1;
            POL_LOW:  qualOk = ~qualBit;
            POL_HIGH: qualOk = qualBit;
            default:  qualOk = 1'b1;
        endcase
    end

    assign strobeEdge = srcStrobe & ~strobePrevReg;
    assign dataEdge   = (srcWord != portPrevReg) && (srcStrobe != strobePrevReg);
    assign capture    = strobeEdge & qualOk & ~dataEdge;

    always_ff @(posedge mclk) begin
        if (srst) begin
            portPrevReg   <= 32'h0;
            strobePrevReg <= 1'b0;
        end else begin
            portPrevReg   <= srcWord;
            strobePrevReg <= srcStrobe;
        end
    end

    // ****************************************
    // codeword capture
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            codewordReg <= 10'h0;
            cwValidReg  <= 1'b0;
        end else begin
            cwValidReg <= capture;
            if (capture) begin
                codewordReg <= extract(srcWord, cfgReg[CFG_SHIFT_LSB +: 5],
                                       cfgReg[CFG_MASK_LSB +: CW_WIDTH]);
            end
        end
    end

    assign codeword      = codewordReg;
    assign codewordValid = cwValidReg;

    // ****************************************
    // sequencer trigger source
    // ****************************************
    // trigger source select
    always_comb begin
        case (ctrlReg[CTRL_SRC_LSB +: 2])
            2'h0:    digSel = trigFire;
            2'h1:    digSel = auxFire;
            2'h2:    digSel = capture;
            default: digSel = |digS2Reg;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            seqTrigReg <= 1'b0;
        end else begin
            seqTrigReg <= digSel;
        end
    end

    assign seqTrig = seqTrigReg;

    // ****************************************
    // line level history
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            highReg <= 32'h0;
            lowReg  <= 32'h0;
        end else if (regWr && regAddr == OFS_HIGH) begin
            highReg <= 32'h0; // a write to OFS_HIGH restarts both histories
            lowReg  <= 32'h0;
        end else begin
            highReg <= highReg | srcWord;
            lowReg  <= lowReg | ~srcWord;
        end
    end

    // ****************************************
    // synchronised start
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            startedReg <= 1'b0;
        end else if (!ctrlReg[CTRL_START_BIT]) begin
            startedReg <= 1'b0;
        end else if (!ctrlReg[CTRL_SYNC_BIT] || ctlS2Reg[5]) begin
            startedReg <= 1'b1;
        end
    end

    assign syncReady = ctrlReg[CTRL_SYNC_BIT] & ctrlReg[CTRL_START_BIT];
    assign progStart = startedReg;

    // ****************************************
    // sticky status and interrupt
    // ****************************************
    assign events = {capture, dataEdge, auxFire, trigFire};
    assign w1c    = (regWr && regAddr == OFS_STATUS) ? regWdata[ST_WIDTH-1:0] : '0;

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            statusReg <= '0;
        end else begin
            statusReg <= (statusReg & ~w1c) | events;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            maskReg <= '0;
        end else if (regWr && regAddr == OFS_MASK) begin
            maskReg <= regWdata[ST_WIDTH-1:0];
        end
    end

    assign irq = |(statusReg & maskReg);

    // ****************************************
    // register writes
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrlReg <= CTRL_RESET;
            cfgReg  <= CFG_RESET;
        end else if (regWr && regAddr == OFS_CTRL) begin
            ctrlReg <= regWdata & 32'h0000_1fff;
        end else if (regWr && regAddr == OFS_CW_CFG) begin
            cfgReg <= regWdata & 32'h0003_ff1f;
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            regRdataReg <= 32'h0;
        end else if (regRd) begin
            if (regAddr == OFS_CTRL) begin
                regRdataReg <= ctrlReg;
            end else if (regAddr == OFS_CW_CFG) begin
                regRdataReg <= cfgReg;
            end else if (regAddr == OFS_STATUS) begin
                regRdataReg <= {28'h0, statusReg};
            end else if (regAddr == OFS_MASK) begin
                regRdataReg <= {28'h0, maskReg};
            end else if (regAddr == OFS_HIGH) begin
                regRdataReg <= highReg;
            end else if (regAddr == OFS_LOW) begin
                regRdataReg <= lowReg;
            end else if (regAddr == OFS_CODE) begin
                regRdataReg <= {22'h0, codewordReg};
            end else if (regAddr == OFS_STATE) begin
                regRdataReg <= {29'h0, startedReg,
                                ctrlReg[CTRL_SRC_LSB +: 2] == 2'h2, qualOk};
            end else begin
                regRdataReg <= 32'h0; // unmapped
            end
        end else begin
            regRdataReg <= 32'h0;
        end
    end

    assign regRdata = regRdataReg;
endmodule

/* logic/cw_trig_pkg.sv */
package cw_trig_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00; // control bits
    localparam logic [7:0] OFS_CW_CFG  = 8'h04; // shift and mask
    localparam logic [7:0] OFS_STATUS  = 8'h08; // sticky events, write one to clear
    localparam logic [7:0] OFS_MASK    = 8'h0c; // interrupt mask
    localparam logic [7:0] OFS_HIGH    = 8'h10; // lines seen high
    localparam logic [7:0] OFS_LOW     = 8'h14; // lines seen low
    localparam logic [7:0] OFS_CODE    = 8'h18; // captured codeword
    localparam logic [7:0] OFS_STATE   = 8'h1c; // live state bits

    // ****************************************
    // control register fields
    // ****************************************
    localparam int CTRL_SLOPE_LSB = 0;  // 2 bits, slope select
    localparam int CTRL_SRC_LSB   = 2;  // 2 bits, trigger source
    localparam int CTRL_LINK_BIT  = 4;  // 1 = take data from sync link
    localparam int CTRL_VIDX_LSB  = 5;  // 4 bits, qualifier index minus 16
    localparam int CTRL_VPOL_LSB  = 9;  // 2 bits, qualifier polarity
    localparam int CTRL_SYNC_BIT  = 11; // sync enable
    localparam int CTRL_START_BIT = 12; // request program start
    localparam int CFG_SHIFT_LSB  = 0;  // 5 bits, codeword shift
    localparam int CFG_MASK_LSB   = 8;  // 10 bits, codeword mask

    // ****************************************
    // status bits
    // ****************************************
    localparam int ST_TRIG   = 0; // main trigger seen
    localparam int ST_AUX    = 1; // auxiliary trigger seen
    localparam int ST_TERR   = 2; // strobe timing error
    localparam int ST_CWORD  = 3; // codeword captured
    localparam int ST_WIDTH  = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET  = 32'h0003_ff00; // full mask, no shift
    localparam int CW_WIDTH = 10;

    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [1:0] {SLOPE_RISE, SLOPE_FALL, SLOPE_BOTH, SLOPE_LEVEL} slope_e;
    typedef enum logic [1:0] {POL_NONE, POL_LOW, POL_HIGH, POL_ANY} vpol_e;
endpackage

/* logic/edge_sense.sv */
`timescale 1ns/100ps
// trigger edge/level detector on an already synchronised level
module edge_sense
    import cw_trig_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       level,
    input  wire logic [1:0] slope,
    output logic            fire
);
    logic prevReg; // last sampled level

    // ****************************************
    // previous level
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            prevReg <= 1'b0;
        end else begin
            prevReg <= level;
        end
    end

    // ****************************************
    // edge or level decision
    // ****************************************
    always_comb begin
        case (slope_e'(slope))
            SLOPE_RISE: fire = level & ~prevReg;
            SLOPE_FALL: fire = ~level & prevReg;
            SLOPE_BOTH: fire = level ^ prevReg;
            default:    fire = level; // level sensitive
        endcase
    end
endmodule

/* testbench/cw_trig_monitor.sv */
`timescale 1ns/100ps
// ****
// port checks
// ****
module cw_trig_monitor
    import cw_trig_pkg::*;
(
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic        portStrobe,
    input wire logic        linkStrobe,
    input wire logic        syncAllReady,
    input wire logic        syncReady,
    input wire logic        progStart,
    input wire logic [9:0]  codeword,
    input wire logic        codewordValid,
    input wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic [3:0] maskSh; // mirror of the mask bits
    // mirror follows software writes only
    always_ff @(posedge mclk) begin
        if (srst)
            maskSh <= 4'h0;
        else if (regWr && regAddr == OFS_MASK)
            maskSh <= regWdata[3:0];
    end
    property p_rd_quiet;
        !$past(regRd) |-> regRdata == 32'h0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read data outside its slot");
    property p_cwv_single;
        codewordValid |=> !codewordValid;
    endproperty
    a_cwv_single: assert property (p_cwv_single)
        else $error("codeword pulse too long");
    property p_cw_hold;
        !codewordValid |-> $stable(codeword);
    endproperty
    a_cw_hold: assert property (p_cw_hold)
        else $error("codeword moved without capture");
    property p_cwv_cause;
        codewordValid |-> $past(portStrobe, 2) || $past(portStrobe, 3)
            || $past(linkStrobe) || $past(linkStrobe, 2) || $past(linkStrobe, 3);
    endproperty
    a_cwv_cause: assert property (p_cwv_cause)
        else $error("capture without strobe");
    property p_start_gate;
        $rose(progStart) && syncReady |->
            $past(syncAllReady) || $past(syncAllReady, 2) || $past(syncAllReady, 3);
    endproperty
    a_start_gate: assert property (p_start_gate)
        else $error("start before all ready");
    property p_mask_read;
        $past(regRd) && !$past(srst) && $past(regAddr) == OFS_MASK
            |-> regRdata[3:0] == $past(maskSh);
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask readback wrong");
    property p_code_read;
        $past(regRd) && !$past(srst) && $past(regAddr) == OFS_CODE
            |-> regRdata[9:0] == $past(codeword);
    endproperty
    a_code_read: assert property (p_code_read)
        else $error("codeword readback wrong");
    property p_irq_masked;
        maskSh == 4'h0 |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt while masked");
endmodule
bind codeword_trigger_front_end cw_trig_monitor cw_trig_monitor_inst (.mclk, .srst, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .portStrobe, .linkStrobe, .syncAllReady,
    .syncReady, .progStart, .codeword, .codewordValid, .irq);

/* testbench/port_ctl.sv */
`timescale 1ns/100ps
// far-side controller on the parallel port
module port_ctl #(
    parameter int HOLD = 3 // strobe high time, cycles
) (
    input  wire logic        mclk,
    output logic      [31:0] portData,
    output logic             portStrobe
);
    initial begin
        portData = 32'h0;
        portStrobe = 1'b0;
    end
    // word settles an edge before strobe, clash only on request
    task automatic putWord(input logic [31:0] w, input bit clash);
        @(posedge mclk);
        portData <= w;
        if (!clash)
            @(posedge mclk);
        portStrobe <= 1'b1;
        repeat (HOLD) @(posedge mclk);
        portStrobe <= 1'b0;
        @(posedge mclk);
        portData <= ~w; // released: never the stale word
    endtask
endmodule

/* testbench/codeword_trigger_front_end_tb_top.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module codeword_trigger_front_end_tb_top;
    import cw_trig_pkg::*;
    logic        mclk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [7:0]  regAddr = 8'h0;
    logic [31:0] regWdata = 32'h0, regRdata, portData, linkData = 32'h0, v;
    logic        portStrobe, linkStrobe = 1'b0, trigIn = 1'b0, auxTrigIn = 1'b0;
    logic [3:0]  digTrig = 4'h0;
    logic        syncAllReady = 1'b0, syncReady, progStart, seqTrig, codewordValid, irq;
    logic [9:0]  codeword, cw;
    bit          got;
    int          error_cnt = 0, check_count = 0;
    int          sh[4] = '{4, 31, 0, 0}, vi[4] = '{15, 15, 0, 0};
    logic [9:0]  mk[4] = '{10'h3f3, 10'h3ff, 10'h3ff, 10'h3ff};
    logic [31:0] wv[4] = '{32'h8000_abcd, 32'h8000_0000, 32'h8000_0155, 32'h0001_0155};
    always #12.5 mclk = ~mclk;
    codeword_trigger_front_end codeword_trigger_front_end_inst (.mclk, .srst, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .portData, .portStrobe, .linkData, .linkStrobe,
        .trigIn, .auxTrigIn, .digTrig, .syncAllReady, .syncReady, .progStart, .seqTrig,
        .codeword, .codewordValid, .irq);
    port_ctl port_ctl_inst (.mclk, .portData, .portStrobe);
    // ****
    // access tasks
    // ****
    function automatic logic [31:0] ctl(int s, int src, int lk, int vx, int vp, int sy);
        return 32'(s | src << 2 | lk << 4 | vx << 5 | vp << 9 | sy * 32'h1800);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    // data valid only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask
    task automatic waitCw(output bit g, output logic [9:0] c);
        g = 1'b0;
        c = 10'h0;
        repeat (12) begin
            @(posedge mclk);
            #1 if (codewordValid === 1'b1 && !g) begin
                g = 1'b1;
                c = codeword;
            end
        end
    endtask
    task automatic watch(output bit g);
        g = 1'b0;
        repeat (12) begin
            @(posedge mclk);
            #1 g |= (seqTrig === 1'b1);
        end
    endtask
    task automatic fire(input int k);
        if (k == 2)
            port_ctl_inst.putWord(32'h0000_0001, 1'b0);
        else begin
            @(posedge mclk);
            if (k == 0) trigIn <= 1'b1;
            else if (k == 1) auxTrigIn <= 1'b1;
            else digTrig <= 4'h1;
            repeat (4) @(posedge mclk);
            trigIn <= 1'b0;
            auxTrigIn <= 1'b0;
            digTrig <= 4'h0;
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end
    // ****
    // scenarios
    // ****
    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        rdChk(OFS_CTRL, CTRL_RESET);
        rdChk(OFS_CW_CFG, CFG_RESET);
        rdChk(OFS_STATUS, 32'h0);
        // all lines idle low since reset
        rdChk(OFS_HIGH, 32'h0);
        rdChk(OFS_LOW, 32'hffff_ffff);
        rdChk(8'h40, 32'h0);
        wr(OFS_MASK, 32'hf);
        rdChk(OFS_MASK, 32'hf);
        // qualifier low on bit 31, every polarity
        for (int p = 0; p < 4; p++) begin
            wr(OFS_CTRL, ctl(0, 2, 0, 15, p, 0));
            fork port_ctl_inst.putWord(32'h0000_0155, 1'b0); waitCw(got, cw); join
            `CHK(got, bit'(p != POL_HIGH))
            `CHK(cw, got ? 10'h155 : 10'h0)
        end
        `CHK(irq, 1'b1)
        wr(OFS_STATUS, 32'hf);
        rdChk(OFS_STATUS, 32'h0);
        `CHK(irq, 1'b0)
        // index, shift and mask edges
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, ctl(0, 2, 0, vi[i], 2, 0));
            wr(OFS_CW_CFG, 32'(sh[i] | mk[i] << 8));
            fork port_ctl_inst.putWord(wv[i], 1'b0); waitCw(got, cw); join
            `CHK(got, bit'(wv[i][16 + vi[i]]))
            if (got) `CHK(cw, 10'((wv[i] >> sh[i]) & mk[i]))
        end
        rdChk(OFS_CODE, 32'h155);
        // drop the capture flags so only the clash is left
        wr(OFS_STATUS, 32'hf);
        fork port_ctl_inst.putWord(32'h1235_5678, 1'b1); waitCw(got, cw); join
        `CHK(got, 1'b0)
        repeat (20) @(posedge mclk);
        rdChk(OFS_STATUS, 32'h4);
        wr(OFS_STATUS, 32'h4);
        rdChk(OFS_STATUS, 32'h0);
        wr(OFS_HIGH, 32'h0);
        repeat (4) @(posedge mclk);
        rdChk(OFS_HIGH, ~32'h1235_5678);
        rdChk(OFS_LOW, 32'h1235_5678);
        // four slopes on main input, then other sources
        for (int k = 0; k < 7; k++) begin
            wr(OFS_STATUS, 32'hf);
            wr(OFS_CTRL, ctl(k < 4 ? k : 0, k < 4 ? 0 : k - 3, 0, 0, 0, 0));
            rd(OFS_STATE, v);
            `CHK(v[1], 1'(k == 5))
            fork fire(k < 4 ? 0 : k - 3); watch(got); join
            `CHK(got, 1'b1)
            rd(OFS_STATUS, v);
            `CHK(v[1:0], k == 4 ? 2'h2 : (k < 4 ? 2'h1 : 2'h0))
        end
        // link selected: port ignored
        wr(OFS_CTRL, ctl(0, 2, 1, 0, 0, 0));
        fork port_ctl_inst.putWord(32'h0000_0077, 1'b0); waitCw(got, cw); join
        `CHK(got, 1'b0)
        @(posedge mclk);
        linkData <= 32'h0000_002a;
        fork
            begin
                @(posedge mclk);
                linkStrobe <= 1'b1;
                repeat (3) @(posedge mclk);
                linkStrobe <= 1'b0;
            end
            waitCw(got, cw);
        join
        `CHK(cw, 10'h2a)
        // start held until peers ready
        wr(OFS_CTRL, ctl(0, 0, 0, 0, 0, 1));
        repeat (10) @(posedge mclk);
        // look after the edge, not in the step that launches outputs
        #1;
        `CHK(progStart, 1'b0)
        `CHK(syncReady, 1'b1)
        @(posedge mclk);
        syncAllReady <= 1'b1;
        for (int n = 0; n < 10 && progStart !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        `CHK(progStart, 1'b1)
        // started, main trigger source, qualifier ignored
        rdChk(OFS_STATE, 32'h5);
        results();
    end
endmodule
